// file: src/ciexu_top.sv
`timescale 1ns/1ps
// interrupt and exception unit with axi4-lite register access
module ciexu_top
   import ciexu_pkg::*;
#(
   parameter logic [23:0] vector_base_default = VBASE_DEFAULT,
   parameter logic [7:0] software_vector_offset = SOFT_VEC_DEFAULT,
   parameter logic [7:0] timer_vector_offset = EXPIRY_VEC_DEFAULT,
   parameter logic [7:0] external_vector_offset = EXT_VEC_DEFAULT,
   parameter logic [7:0] bus_fault_vector_offset = BFAULT_VEC_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core side
   input wire logic [31:0] next_pc,
   input wire logic trap_exec,
   input wire logic [3:0] trap_code,
   input wire logic return_exec,
   input wire logic insn_retire,
   input wire logic count_expiry_req,
   input wire logic [NUM_EXT_LINES-1:0] external_irq_line,
   input wire logic bus_error_input,
   input wire logic bus_error_fetch,
   // branch request to the fetch stage, then status word, return address and step state
   output logic redirect_valid,
   output logic [31:0] redirect_addr,
   output logic [31:0] status_word,
   output logic [31:0] return_addr,
   output logic step_active
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0] status_ff;
   logic [31:0] nxt_status;
   logic [31:0] ret_ff;
   logic [31:0] nxt_ret;
   logic [23:0] vbase_ff;
   logic [23:0] vbase_stage_ff;
   logic [1:0] vbase_cnt_ff;
   logic step_armed_ff;
   logic boot_pend_ff;
   logic redir_ff;
   logic [31:0] redir_addr_ff;
   logic [31:0] nxt_redir_addr;
   logic nxt_redir;
   // axi
   logic awready_ff;
   logic wready_ff;
   logic aw_held_ff;
   logic w_held_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   // event decode
   logic wr_fire;
   logic wr_status;
   logic wr_vbase;
   logic [31:0] wr_merged;
   logic [31:0] wr_base;
   logic in_service;
   logic stepping;
   logic maskable_ok;
   logic step_hit;
   logic expiry_hit;
   logic ext_hit;
   logic [NUM_EXT_LINES-1:0] ext_req;
   logic [NUM_EXT_LINES-1:0] ext_grant;
   logic [23:0] vb;

   // qualifiers taken from the status word
   assign in_service = status_ff[BIT_IN_SERVICE];
   assign stepping = step_armed_ff & status_ff[BIT_SINGLE_STEP];
   assign vb = vbase_ff;

   // ----------------------------------------------------------------
   // axi write channel
   // ----------------------------------------------------------------
   assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_status = wr_fire & (awaddr_ff == ADDR_STATUS_WORD);
   assign wr_vbase = wr_fire & (awaddr_ff == ADDR_VECTOR_BASE);

   // address and data taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (ce) begin
         awready_ff <= ~aw_held_ff & ~(s_axi_awvalid & awready_ff) & ~wr_fire;
         wready_ff <= ~w_held_ff & ~(s_axi_wvalid & wready_ff) & ~wr_fire;
         if (s_axi_awvalid && awready_ff) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // write response after both halves arrive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff == ADDR_STATUS_WORD || awaddr_ff == ADDR_VECTOR_BASE ||
                         awaddr_ff == ADDR_RETURN_ADDR) ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // byte-lane merge onto the addressed register
   always_comb begin
      case (awaddr_ff)
         ADDR_VECTOR_BASE: wr_base = {vbase_stage_ff, 8'h00};
         ADDR_RETURN_ADDR: wr_base = ret_ff;
         default: wr_base = status_ff;
      endcase
      for (int b = 0; b < 4; b++) begin
         wr_merged[b*8 +: 8] = wstrb_ff[b] ? wdata_ff[b*8 +: 8] : wr_base[b*8 +: 8];
      end
   end

   // ----------------------------------------------------------------
   // axi read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (ce) begin
         arready_ff <= ~rvalid_ff & ~(s_axi_arvalid & arready_ff);
         if (s_axi_arvalid && arready_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (s_axi_araddr)
               ADDR_STATUS_WORD: rdata_ff <= status_ff;
               ADDR_VECTOR_BASE: rdata_ff <= {vbase_ff, 8'h00};
               ADDR_RETURN_ADDR: rdata_ff <= ret_ff;
               // unmapped offsets answer zero data and decode error
               default: begin
                  rdata_ff <= 32'h0000_0000;
                  rresp_ff <= RESP_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // vector base, two-cycle write
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vbase_ff <= vector_base_default;
         vbase_stage_ff <= vector_base_default;
         vbase_cnt_ff <= 2'h0;
      end else if (ce) begin
         if (wr_vbase) begin
            vbase_stage_ff <= wr_merged[31:VEC_BASE_LSB];
            vbase_cnt_ff <= VBASE_WR_CYCLES - 2'h1;
         end else if (vbase_cnt_ff != 2'h0) begin
            // staged value lands on the second edge
            vbase_cnt_ff <= vbase_cnt_ff - 2'h1;
            if (vbase_cnt_ff == 2'h1) begin
               vbase_ff <= vbase_stage_ff;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   assign maskable_ok = status_ff[BIT_GLOBAL_EN] & ~in_service & ~stepping;
   assign expiry_hit = count_expiry_req & maskable_ok;
   assign ext_req = external_irq_line & status_ff[LINE_MASK_LSB +: NUM_EXT_LINES];
   assign ext_hit = (|ext_req) & maskable_ok;
   assign step_hit = stepping & insn_retire & ~in_service;

   ciexu_line_prio #(
      .N(NUM_EXT_LINES)
   ) u_prio (
      .req(ext_req),
      .grant(ext_grant)
   );

   // next status word, return address and branch target
   always_comb begin
      nxt_status = wr_status ? wr_merged : status_ff;
      nxt_ret = (wr_fire && awaddr_ff == ADDR_RETURN_ADDR) ? wr_merged : ret_ff;
      nxt_redir = 1'b0;
      nxt_redir_addr = redir_addr_ff;
      if (return_exec) begin
         nxt_status[BIT_IN_SERVICE] = nxt_status[BIT_SAVED_SERVICE];
         nxt_status[BIT_SAVED_SERVICE] = 1'b0;
         nxt_redir = 1'b1;
         nxt_redir_addr = ret_ff;
      end
      // hardware events win over a same-cycle software write
      if (bus_error_input || trap_exec || step_hit || expiry_hit || ext_hit) begin
         nxt_status[BIT_SAVED_SERVICE] = nxt_status[BIT_IN_SERVICE];
         nxt_status[BIT_IN_SERVICE] = 1'b1;
         nxt_ret = next_pc;
         nxt_redir = 1'b1;
         // bus error outranks trap, step, timer and external
         if (bus_error_input) begin
            if (bus_error_fetch) begin
               nxt_status[BIT_FETCH_BERR] = 1'b1;
            end else begin
               nxt_status[BIT_DATA_BERR] = 1'b1;
            end
            nxt_redir_addr = {vb, bus_fault_vector_offset};
         end else if (trap_exec) begin
            nxt_status[BIT_SOFT_CAUSE] = 1'b1;
            nxt_status[TRAP_CODE_LSB +: TRAP_CODE_W] = trap_code;
            nxt_redir_addr = {vb, software_vector_offset};
         end else if (step_hit) begin
            nxt_status[BIT_SOFT_CAUSE] = 1'b0;
            nxt_status[STEP_FIELD_LSB +: STEP_FIELD_W] = STEP_FIELD_ONES;
            nxt_redir_addr = {vb, software_vector_offset};
         end else if (expiry_hit) begin
            nxt_status[BIT_EXPIRY_CAUSE] = 1'b1;
            nxt_redir_addr = {vb, timer_vector_offset};
         end else begin
            nxt_status[BIT_EXT_CAUSE] = 1'b1;
            nxt_status[LINE_STAT_LSB +: NUM_EXT_LINES] = ext_grant;
            nxt_redir_addr = {vb, external_vector_offset};
         end
      end
   end

   // ----------------------------------------------------------------
   // status word, return address, stepping
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= STATUS_WORD_RESET;
         ret_ff <= RESET_VECTOR;
      end else if (ce) begin
         status_ff <= nxt_status;
         ret_ff <= nxt_ret;
      end
   end

   // stepping arms only on the return jump
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_armed_ff <= 1'b0;
      end else if (ce) begin
         if (!nxt_status[BIT_SINGLE_STEP]) begin
            step_armed_ff <= 1'b0;
         end else if (return_exec) begin
            step_armed_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // branch request, reset vector first
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_pend_ff <= 1'b1;
         redir_ff <= 1'b0;
         redir_addr_ff <= RESET_VECTOR;
      end else if (ce) begin
         // reset vector is issued once, on the first enabled edge
         boot_pend_ff <= 1'b0;
         if (boot_pend_ff) begin
            redir_ff <= 1'b1;
            redir_addr_ff <= RESET_VECTOR;
         end else begin
            redir_ff <= nxt_redir;
            redir_addr_ff <= nxt_redir_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // axi channel outputs
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // core-side outputs
   assign redirect_valid = redir_ff;
   assign redirect_addr = redir_addr_ff;
   assign status_word = status_ff;
   assign return_addr = ret_ff;
   assign step_active = step_armed_ff;
endmodule // ciexu_top

// file: src/ciexu_pkg.sv
// How it works
// - vector address is base register upper 24 bits joined to an 8-bit offset
// - base register write completes after two cycles; reset loads configured default
// - accepting any event copies in-service to saved-in-service, then sets in-service
// - return jump copies saved-in-service into in-service, then clears saved-in-service
// - software status word writes update in-service and saved-in-service directly
// - branch issued within four cycles; pending units keep running
// - timer and external events refused while global enable low or in-service set
// - reset branches to address zero, non-maskable
// - trap branches to offset 0x4, saves next address, sets software cause and in-service
// - trap low four code bits copied into status bits 19:16
// - trap taken even while in-service, overwriting return register
// - timer cause and line masks unchanged by trap and return
// - timer event branches to 0x8, saves next address, sets timer cause, in-service
// - six external lines, masks at bits 20..25, gated by global enable
// - level lines branch to 0x0c, set external cause, in-service, line status 26..31
// - line zero highest priority, line five lowest
// - bus error non-maskable; bit 15 for fetch, bit 14 for data
// - bus error at offset 16 is imprecise; return address only near fault
// - single step armed by return jump; each instruction traps, bits 23:16 ones
// - while stepping return register holds next address; timer, external blocked
package ciexu_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_STATUS_WORD = 4'h0;
   localparam logic [3:0] ADDR_VECTOR_BASE = 4'h4;
   localparam logic [3:0] ADDR_RETURN_ADDR = 4'h8;
   localparam logic [31:0] STATUS_WORD_RESET = 32'h0000_0000;
   // ----------------------------------------------------------------
   // status word fields
   // ----------------------------------------------------------------
   localparam int BIT_SOFT_CAUSE = 0;
   localparam int BIT_EXT_CAUSE = 1;
   localparam int BIT_EXPIRY_CAUSE = 2;
   localparam int BIT_IN_SERVICE = 3;
   localparam int BIT_GLOBAL_EN = 5;
   localparam int BIT_SAVED_SERVICE = 6;
   localparam int BIT_SINGLE_STEP = 10;
   localparam int BIT_DATA_BERR = 14;
   localparam int BIT_FETCH_BERR = 15;
   localparam int TRAP_CODE_LSB = 16;
   localparam int TRAP_CODE_W = 4;
   localparam int STEP_FIELD_LSB = 16;
   localparam int STEP_FIELD_W = 8;
   localparam int LINE_MASK_LSB = 20;
   localparam int LINE_STAT_LSB = 26;
   localparam int NUM_EXT_LINES = 6;
   // ----------------------------------------------------------------
   // vectors and timing
   // ----------------------------------------------------------------
   localparam int VEC_BASE_LSB = 8;
   localparam int VEC_BASE_W = 24;
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   localparam logic [7:0] SOFT_VEC_DEFAULT = 8'h04;
   localparam logic [7:0] EXPIRY_VEC_DEFAULT = 8'h08;
   localparam logic [7:0] EXT_VEC_DEFAULT = 8'h0c;
   localparam logic [7:0] BFAULT_VEC_DEFAULT = 8'h10;
   localparam logic [23:0] VBASE_DEFAULT = 24'h000000;
   localparam logic [1:0] VBASE_WR_CYCLES = 2'h2;
   localparam logic [STEP_FIELD_W-1:0] STEP_FIELD_ONES = 8'hff;
   // ----------------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: src/ciexu_line_prio.sv
`timescale 1ns/1ps
// fixed priority pick, lowest index wins
module ciexu_line_prio #(
   parameter int N = 6
) (
   input wire logic [N-1:0] req,
   output logic [N-1:0] grant
);
   logic [N-1:0] taken;

   // ----------------------------------------------------------------
   // priority chain
   // ----------------------------------------------------------------
   assign taken[0] = 1'b0;
   for (genvar i = 0; i < N; i++) begin : g_line
      assign grant[i] = req[i] & ~taken[i];
      if (i < N - 1) begin : g_chain
         assign taken[i+1] = taken[i] | req[i];
      end
   end
endmodule // ciexu_line_prio

// file: testbench/ciexu_monitor.sv
`timescale 1ns/1ps
module ciexu_monitor
   import ciexu_pkg::*;
#(
   parameter logic [7:0] software_vector_offset = SOFT_VEC_DEFAULT,
   parameter logic [7:0] timer_vector_offset = EXPIRY_VEC_DEFAULT,
   parameter logic [7:0] external_vector_offset = EXT_VEC_DEFAULT,
   parameter logic [7:0] bus_fault_vector_offset = BFAULT_VEC_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] next_pc,
   input wire logic trap_exec,
   input wire logic [3:0] trap_code,
   input wire logic return_exec,
   input wire logic insn_retire,
   input wire logic count_expiry_req,
   input wire logic [NUM_EXT_LINES-1:0] external_irq_line,
   input wire logic bus_error_input,
   input wire logic bus_error_fetch,
   input wire logic redirect_valid,
   input wire logic [31:0] redirect_addr,
   input wire logic [31:0] status_word,
   input wire logic [31:0] return_addr,
   input wire logic step_active
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [31:0] sw;
   logic [5:0] m;
   logic [5:0] lo;
   logic q;
   // enabled lines and the winning one
   assign sw = status_word;
   assign m = external_irq_line & status_word[25:20];
   assign lo = m & (~m + 6'h01);
   assign q = ce && !trap_exec && !bus_error_input && !return_exec;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_branch(logic [7:0] off);
      redirect_valid ##0 redirect_addr[7:0] == off;
   endsequence
   property p_reset;
      !$past(aresetn) && ce |=> redirect_valid && redirect_addr == RESET_VECTOR;
   endproperty
   property p_trap;
      trap_exec && ce && !bus_error_input |=> s_branch(software_vector_offset) ##0 sw[0] && sw[3]
         && sw[6] == $past(sw[3]) && sw[19:16] == $past(trap_code) && return_addr == $past(next_pc);
   endproperty
   property p_ret;
      return_exec && ce && sw[3] && !trap_exec && !bus_error_input && !step_active |=> redirect_valid
         && redirect_addr == $past(return_addr) && sw[3] == $past(sw[6]) && !sw[6];
   endproperty
   property p_block;
      $past(aresetn) && count_expiry_req && (!sw[5] || sw[3]) && q && !(step_active && insn_retire)
         |=> !redirect_valid;
   endproperty
   property p_timer;
      sw[5] && !sw[3] && count_expiry_req && q && !step_active |=> s_branch(timer_vector_offset) ##0 sw[2] && sw[3];
   endproperty
   property p_ext;
      sw[5] && !sw[3] && !count_expiry_req && (|m) && q && !step_active
         |=> s_branch(external_vector_offset) ##0 sw[1] && sw[31:26] == $past(lo);
   endproperty
   property p_berr;
      bus_error_input && ce |=> s_branch(bus_fault_vector_offset) ##0 ($past(bus_error_fetch) ? sw[15] : sw[14]);
   endproperty
   property p_step;
      step_active && insn_retire && !sw[3] && q |=> s_branch(software_vector_offset) ##0 sw[23:16] == 8'hff
         && !sw[0] && return_addr == $past(next_pc);
   endproperty
   a_reset: assert property (p_reset) else $error("reset branch missing");
   a_trap: assert property (p_trap) else $error("trap entry wrong");
   a_ret: assert property (p_ret) else $error("return jump wrong");
   a_block: assert property (p_block) else $error("blocked event taken");
   a_timer: assert property (p_timer) else $error("timer entry wrong");
   a_ext: assert property (p_ext) else $error("external entry wrong");
   a_berr: assert property (p_berr) else $error("bus fault entry wrong");
   a_step: assert property (p_step) else $error("step entry wrong");
endmodule // ciexu_monitor

bind ciexu_top ciexu_monitor #(
   .software_vector_offset(software_vector_offset),
   .timer_vector_offset(timer_vector_offset),
   .external_vector_offset(external_vector_offset),
   .bus_fault_vector_offset(bus_fault_vector_offset)
) mon (.*);

// file: testbench/ciexu_irq_source.sv
`timescale 1ns/1ps
module ciexu_irq_source (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] raise,
   input wire logic [5:0] clear,
   input wire logic berr_req,
   input wire logic berr_fetch,
   output logic [5:0] external_irq_line,
   output logic bus_error_input,
   output logic bus_error_fetch
);
   // lines stay high until cleared at the source
   always_ff @(posedge aclk) begin
      external_irq_line <= aresetn ? (external_irq_line | raise) & ~clear : 6'h00;
   end
   // one-cycle fault; qualifier toggles while idle
   always_ff @(posedge aclk) begin
      bus_error_input <= aresetn && berr_req;
      bus_error_fetch <= berr_req ? berr_fetch : (aresetn ? ~bus_error_fetch : 1'h0);
   end
endmodule // ciexu_irq_source

// file: testbench/test_core_interrupt_exception_unit.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_core_interrupt_exception_unit;
   import ciexu_pkg::*;
   logic aclk = 0, aresetn = 0, ce = 1, trap_exec = 0, return_exec = 0, insn_retire = 0, count_expiry_req = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, trap_code = 0;
   logic [31:0] s_axi_wdata = 0, next_pc = 0, s_axi_rdata, redirect_addr, status_word, return_addr, d;
   logic [5:0] raise = 0, clear = 0, external_irq_line;
   logic berr_req = 0, berr_fetch = 0, bus_error_input, bus_error_fetch, redirect_valid, step_active;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int mismatches = 0, comparisons = 0;
   ciexu_top uut (.*);
   ciexu_irq_source src (.*);
   always #5 aclk = ~aclk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      logic aw, w;
      n = 0;
      aw = 1;
      w = 1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while ((aw || w || s_axi_bvalid !== 1'h1) && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) aw = 0;
         if (s_axi_wready) w = 0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n >= 50) mismatches++;
   endtask
   task axi_rd(input logic [3:0] a);
      int n;
      logic ar;
      n = 0;
      ar = 1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while ((ar || s_axi_rvalid !== 1'h1) && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) ar = 0;
         s_axi_arvalid <= ar;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n >= 50) mismatches++;
   endtask
   // waits a bounded time for the branch pulse
   task take(input logic [31:0] exp);
      int n;
      n = 0;
      #1;
      while (redirect_valid !== 1'h1 && n < 4) begin
         @(posedge aclk);
         #1;
         n++;
      end
      `CHK(redirect_valid, 1'h1)
      `CHK(redirect_addr, exp)
   endtask
   task quiet;
      repeat (5) begin
         @(posedge aclk);
         #1;
         `CHK(redirect_valid, 1'h0)
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      axi_rd(4'hc);
      `CHK(r, RESP_DECERR)
      axi_wr(4'h0, 32'h0000_0048);
      `CHK(r, RESP_OKAY)
      axi_rd(4'h0);
      `CHK(d[6:3], 4'h9)
      axi_wr(4'h4, 32'h0000_1200);
      repeat (2) @(posedge aclk);
      axi_rd(4'h4);
      `CHK(d, 32'h0000_1200)
      $display("regs end");
   endtask
   task t_trap;
      axi_wr(4'h0, 32'h03f0_0000);
      next_pc <= 32'h100;
      trap_code <= 4'hf;
      trap_exec <= 1'h1;
      @(posedge aclk) trap_exec <= 1'h0;
      take(32'h1204);
      `CHK(status_word[6:0], 7'h09)
      `CHK(status_word[19:16], 4'hf)
      `CHK(return_addr, 32'h100)
      next_pc <= 32'h200;
      trap_code <= 4'h5;
      trap_exec <= 1'h1;
      @(posedge aclk) trap_exec <= 1'h0;
      take(32'h1204);
      `CHK(status_word[6], 1'h1)
      `CHK(return_addr, 32'h200)
      return_exec <= 1'h1;
      @(posedge aclk) return_exec <= 1'h0;
      take(32'h200);
      `CHK({status_word[6], status_word[3]}, 2'h1)
      `CHK(status_word[25:20], 6'h3f)
      $display("trap end");
   endtask
   task t_timer;
      axi_wr(4'h0, 32'h0);
      count_expiry_req <= 1'h1;
      quiet();
      count_expiry_req <= 1'h0;
      axi_wr(4'h0, 32'h28);
      count_expiry_req <= 1'h1;
      quiet();
      count_expiry_req <= 1'h0;
      axi_wr(4'h0, 32'h20);
      next_pc <= 32'h400;
      count_expiry_req <= 1'h1;
      @(posedge aclk);
      take(32'h1208);
      count_expiry_req <= 1'h0;
      `CHK(status_word[3:2], 2'h3)
      `CHK(return_addr, 32'h400)
      $display("timer end");
   endtask
   task t_ext;
      axi_wr(4'h0, 32'h03e0_0020);
      raise <= 6'h0b;
      @(posedge aclk) raise <= 6'h00;
      take(32'h120c);
      `CHK(status_word[31:26], 6'h02)
      `CHK(status_word[1], 1'h1)
      clear <= 6'h3f;
      @(posedge aclk) clear <= 6'h00;
      axi_wr(4'h0, 32'h0010_0020);
      raise <= 6'h02;
      quiet();
      axi_wr(4'h0, 32'h0030_0000);
      quiet();
      raise <= 6'h00;
      clear <= 6'h3f;
      @(posedge aclk) clear <= 6'h00;
      $display("ext end");
   endtask
   task t_berr;
      next_pc <= 32'h500;
      berr_fetch <= 1'h1;
      berr_req <= 1'h1;
      @(posedge aclk) berr_req <= 1'h0;
      take(32'h1210);
      `CHK(status_word[15], 1'h1)
      berr_fetch <= 1'h0;
      berr_req <= 1'h1;
      @(posedge aclk) berr_req <= 1'h0;
      take(32'h1210);
      `CHK(status_word[14], 1'h1)
      @(posedge aclk) ce <= 1'h0;
      berr_req <= 1'h1;
      @(posedge aclk) berr_req <= 1'h0;
      quiet();
      ce <= 1'h1;
      quiet();
      $display("berr end");
   endtask
   task t_step;
      axi_wr(4'h8, 32'h300);
      axi_wr(4'h0, 32'h0000_0429);
      return_exec <= 1'h1;
      @(posedge aclk) return_exec <= 1'h0;
      take(32'h300);
      `CHK(step_active, 1'h1)
      count_expiry_req <= 1'h1;
      quiet();
      next_pc <= 32'h304;
      insn_retire <= 1'h1;
      @(posedge aclk) insn_retire <= 1'h0;
      take(32'h1204);
      count_expiry_req <= 1'h0;
      `CHK(status_word[23:16], 8'hff)
      `CHK(status_word[0], 1'h0)
      `CHK(return_addr, 32'h304)
      $display("step end");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      take(32'h0);
      t_regs();
      t_trap();
      t_timer();
      t_ext();
      t_berr();
      t_step();
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge aclk);
      mismatches++;
      end_of_test();
   end
endmodule // test_core_interrupt_exception_unit
